// ==== floppy_option_ctrl.sv ====
// What this block does
// - two-sided status low only while selected
// - select strap: stepper unpowered when deselected
// - head-load strap: stepper powered only during head load
// - head load pad drives solenoid from head load
// - strap picks select or head load for indicator
// - write protect blocks internal write gate
// - allow strap lets writes through, status kept
// - strap picks head source: side, select, direction
// - off-delay strap holds motor 20 s after release
// - select control spins up, ready after 700 ms
// - head load control, same timing, exclusive choice
// - radial strap gives per-drive or continuous motor
// - low per-drive motor line stops spindle, undelayed
// - per-drive line needs radial strap, delay elsewhere
// - spindle speed checked against 166.667 ms index period
// - every cable output gated by drive select
`include "floppy_option_regs.svh"
`timescale 1ns/1ns
module floppy_option_ctrl #(
    parameter int unsigned OFF_DELAY_CYCLES =
        32'(64'd`MOTOR_OFF_DELAY_S * 64'd`CLK_FREQ_HZ),
    parameter int unsigned SPIN_UP_CYCLES =
        32'(64'd`SPIN_UP_MS * 64'd`CLK_FREQ_HZ / 64'd`MS_PER_S),
    parameter int unsigned READY_CYCLES =
        32'(64'd`READY_MS * 64'd`CLK_FREQ_HZ / 64'd`MS_PER_S),
    parameter int unsigned INDEX_PERIOD_CYCLES =
        32'(64'd`INDEX_PERIOD_NS / 64'd`CLK_PERIOD_NS),
    parameter int unsigned INDEX_TOL_CYCLES =
        32'(64'd`INDEX_PERIOD_NS / 64'd`CLK_PERIOD_NS * 64'd`SPEED_TOL_PPM
            / 64'd`PPM_SCALE)
) (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        srst,
    // static option straps
    input  wire floppy_option_pkg::straps_t  straps,
    // host cable and sensors
    input  wire floppy_option_pkg::cable_in_t cable_in,
    input  wire floppy_option_pkg::sensor_t  sensors,
    // outputs
    output floppy_option_pkg::cable_out_t    cable_out,
    output floppy_option_pkg::drive_ctl_t    drive_ctl
);
    import floppy_option_pkg::*;

    cable_in_t    cin;
    sensor_t      sns;
    cable_out_t   out_q;
    cable_out_t   out_d;
    drive_ctl_t   ctl_q;
    drive_ctl_t   ctl_d;
    motor_state_t state_q;
    motor_state_t state_d;
    logic [31:0]  delay_q;
    logic [31:0]  delay_d;
    logic [31:0]  spin_q;
    logic [31:0]  spin_d;
    logic [31:0]  idx_cnt_q;
    logic [31:0]  idx_cnt_d;
    logic         speed_ok_q;
    logic         speed_ok_d;
    logic         idx_prev_q;
    logic         idx_prev_d;
    logic         selected;
    logic         head_load_act;
    logic         demand;
    logic         radial_on;
    logic         motor_on_w;
    logic         spin_ready;

    if (SPIN_UP_CYCLES == 0 || READY_CYCLES < SPIN_UP_CYCLES || READY_CYCLES < 2
        || OFF_DELAY_CYCLES == 0 || INDEX_TOL_CYCLES >= INDEX_PERIOD_CYCLES
        || INDEX_PERIOD_CYCLES == '1) begin : g_chk
        $error("floppy_option_ctrl timing parameters out of range");
    end

    // cable and sensor lines come from another domain; straps are static
    pin_sync #(
        .WIDTH ($bits(cable_in_t)),
        .INIT  (`CABLE_IN_IDLE)
    ) u_cable_sync (
        .clock (clock),
        .srst  (srst),
        .d     (cable_in),
        .q     (cin)
    );

    pin_sync #(
        .WIDTH ($bits(sensor_t)),
        .INIT  (`SENSOR_IDLE)
    ) u_sensor_sync (
        .clock (clock),
        .srst  (srst),
        .d     (sensors),
        .q     (sns)
    );

    // this drive answers only to the select line its address strap names
    assign selected      = |(straps.drive_address_straps & ~cin.drive_sel_n);
    assign head_load_act = ~cin.head_load_n;

    // select control wins when both are strapped, so only one source acts
    always_comb begin
        if (straps.motor_from_select) begin
            demand = selected;
        end else if (straps.motor_from_head_load) begin
            demand = head_load_act;
        end else begin
            demand = 1'b0;
        end
    end

    // radial path: low line on the chosen jumper stops it; no jumper runs it
    assign radial_on = straps.radial_motor_enable
        & ~|(straps.per_drive_motor_lines & ~cin.motor_line_n);

    assign motor_on_w = (state_q != MOTOR_IDLE) | radial_on;
    assign spin_ready = spin_q >= READY_CYCLES;

    always_comb begin
        state_d = state_q;
        delay_d = delay_q;
        case (state_q)
            MOTOR_IDLE: begin
                if (demand) begin
                    state_d = MOTOR_RUN;
                end
            end
            MOTOR_RUN: begin
                if (!demand) begin
                    if (straps.motor_off_delay_enable) begin
                        state_d = MOTOR_DELAY;
                        delay_d = OFF_DELAY_CYCLES - `CNT_ONE;
                    end else begin
                        state_d = MOTOR_IDLE;
                    end
                end
            end
            MOTOR_DELAY: begin
                if (demand) begin
                    state_d = MOTOR_RUN;
                    delay_d = `CNT_ZERO;
                end else if (delay_q == `CNT_ZERO) begin
                    state_d = MOTOR_IDLE;
                end else begin
                    delay_d = delay_q - `CNT_ONE;
                end
            end
            default: begin
                state_d = MOTOR_IDLE;
                delay_d = `CNT_ZERO;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= MOTOR_IDLE;
            delay_q <= `CNT_ZERO;
        end else begin
            state_q <= state_d;
            delay_q <= delay_d;
        end
    end

    // run time since spin-up began, saturating at the ready point
    always_comb begin
        spin_d = spin_q;
        if (!motor_on_w) begin
            spin_d = `CNT_ZERO;
        end else if (!spin_ready) begin
            spin_d = spin_q + `CNT_ONE;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            spin_q <= `CNT_ZERO;
        end else begin
            spin_q <= spin_d;
        end
    end

    // leading edge to leading edge of index; the first interval is timed from motor start
    always_comb begin
        idx_prev_d = sns.index_hole;
        idx_cnt_d  = idx_cnt_q;
        speed_ok_d = speed_ok_q;
        if (!motor_on_w) begin
            idx_cnt_d  = `CNT_ZERO;
            speed_ok_d = 1'b0;
        end else if (sns.index_hole && !idx_prev_q) begin
            idx_cnt_d  = `CNT_ZERO;
            speed_ok_d = (idx_cnt_q >= INDEX_PERIOD_CYCLES - INDEX_TOL_CYCLES)
                && (idx_cnt_q <= INDEX_PERIOD_CYCLES + INDEX_TOL_CYCLES);
        end else if (idx_cnt_q > INDEX_PERIOD_CYCLES + INDEX_TOL_CYCLES) begin
            speed_ok_d = 1'b0;
        end else begin
            idx_cnt_d = idx_cnt_q + `CNT_ONE;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            idx_prev_q <= 1'b0;
            idx_cnt_q  <= `CNT_ZERO;
            speed_ok_q <= 1'b0;
        end else begin
            idx_prev_q <= idx_prev_d;
            idx_cnt_q  <= idx_cnt_d;
            speed_ok_q <= speed_ok_d;
        end
    end

    // cable outputs and internal controls
    always_comb begin
        out_d.two_sided_media_status_n = ~(selected & sns.two_sided_hole);
        out_d.write_protect_n = ~(selected & sns.write_protect);
        out_d.index_n         = ~(selected & sns.index_hole);
        out_d.ready_n         = ~(selected & spin_ready);

        ctl_d.write_gate_int = selected & ~cin.write_gate_n
            & ~(sns.write_protect & ~straps.allow_write_on_protect_strap);
        // head load strap takes precedence if both stepper straps are fitted
        if (straps.stepper_power_from_head_load_strap) begin
            ctl_d.stepper_power = head_load_act & selected;
        end else if (straps.stepper_power_from_select_strap) begin
            ctl_d.stepper_power = selected;
        end else begin
            ctl_d.stepper_power = 1'b0;
        end
        if (straps.head_by_side_input_strap) begin
            ctl_d.head_select = ~cin.side_select_n;
        end else if (straps.head_by_select_strap) begin
            ctl_d.head_select =
                |(straps.per_drive_head_select_straps & ~cin.drive_sel_n);
        end else if (straps.head_by_direction_strap) begin
            ctl_d.head_select = ~cin.direction_n;
        end else begin
            ctl_d.head_select = 1'b0;
        end
        ctl_d.head_load_solenoid = straps.head_load_output_pad_strap & head_load_act;
        ctl_d.activity_led = straps.activity_from_head_load_strap
            ? head_load_act : selected;
        ctl_d.lever_lock_enable = straps.activity_from_head_load_strap
            ? head_load_act : selected;
        ctl_d.motor_on = motor_on_w;
        ctl_d.at_speed = motor_on_w & (spin_q >= SPIN_UP_CYCLES);
        ctl_d.speed_ok = speed_ok_q;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            out_q <= '{`LINE_IDLE_N, `LINE_IDLE_N, `LINE_IDLE_N, `LINE_IDLE_N};
            ctl_q <= '0;
        end else begin
            out_q <= out_d;
            ctl_q <= ctl_d;
        end
    end

    assign cable_out = out_q;
    assign drive_ctl = ctl_q;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    property p_two_sided;
        (selected && sns.two_sided_hole) |=> !out_q.two_sided_media_status_n;
    endproperty
    a_two_sided: assert property (p_two_sided) else $error("two-sided status not low");

    property p_gate_outputs;
        !selected |=> (out_q.two_sided_media_status_n && out_q.write_protect_n
            && out_q.index_n && out_q.ready_n);
    endproperty
    a_gate_outputs: assert property (p_gate_outputs) else $error("output while deselected");

    property p_wp_inhibit;
        (sns.write_protect && !straps.allow_write_on_protect_strap) |=> !ctl_q.write_gate_int;
    endproperty
    a_wp_inhibit: assert property (p_wp_inhibit) else $error("write on protected media");

    property p_allow_write;
        (straps.allow_write_on_protect_strap && selected && !cin.write_gate_n
            && sns.write_protect) |=> (ctl_q.write_gate_int && !out_q.write_protect_n);
    endproperty
    a_allow_write: assert property (p_allow_write) else $error("allowed write blocked");

    property p_step_select;
        (straps.stepper_power_from_select_strap && !straps.stepper_power_from_head_load_strap
            && !selected) |=> !ctl_q.stepper_power;
    endproperty
    a_step_select: assert property (p_step_select) else $error("stepper on while deselected");

    property p_step_head_load;
        (straps.stepper_power_from_head_load_strap && cin.head_load_n) |=> !ctl_q.stepper_power;
    endproperty
    a_step_head_load: assert property (p_step_head_load) else $error("stepper without load");

    property p_head_direction;
        (straps.head_by_direction_strap && !straps.head_by_side_input_strap
            && !straps.head_by_select_strap) |=> (ctl_q.head_select == !$past(cin.direction_n));
    endproperty
    a_head_direction: assert property (p_head_direction) else $error("head not by direction");

    property p_off_delay;
        (state_q == MOTOR_RUN && !demand && straps.motor_off_delay_enable)
            |=> (state_q == MOTOR_DELAY && delay_q == OFF_DELAY_CYCLES - `CNT_ONE)
            ##1 ctl_q.motor_on;
    endproperty
    a_off_delay: assert property (p_off_delay) else $error("off delay not started");

    property p_demand_start;
        (demand && state_q == MOTOR_IDLE) |=> (state_q == MOTOR_RUN) ##1 ctl_q.motor_on;
    endproperty
    a_demand_start: assert property (p_demand_start) else $error("motor did not start");

    property p_radial_off;
        (straps.radial_motor_enable && |(straps.per_drive_motor_lines & ~cin.motor_line_n)
            && state_q == MOTOR_IDLE) |=> !ctl_q.motor_on;
    endproperty
    a_radial_off: assert property (p_radial_off) else $error("motor on with line low");

    property p_ready_late;
        $rose(ctl_q.motor_on) |-> out_q.ready_n [*2];
    endproperty
    a_ready_late: assert property (p_ready_late) else $error("ready at spin start");

    c_ready: cover property ($fell(out_q.ready_n));
    c_delay_expire: cover property (state_q == MOTOR_DELAY ##1 state_q == MOTOR_IDLE);
    c_speed_ok: cover property ($rose(ctl_q.speed_ok));
endmodule // floppy_option_ctrl

// ==== floppy_option_regs.svh ====
`ifndef FLOPPY_OPTION_REGS_SVH
`define FLOPPY_OPTION_REGS_SVH

// device clock
`define CLK_FREQ_HZ        100000000
`define CLK_PERIOD_NS      10
`define MS_PER_S           1000

// spindle timing in their own units
`define MOTOR_OFF_DELAY_S  20
`define SPIN_UP_MS         500
`define READY_MS           700
`define INDEX_PERIOD_NS    166667000
`define SPEED_TOL_PPM      12500
`define PPM_SCALE          1000000

// counter constants and idle levels
`define CNT_ZERO           32'h0
`define CNT_ONE            32'h1
`define CABLE_IN_IDLE      12'hfff
`define SENSOR_IDLE        3'h0
`define LINE_IDLE_N        1'b1
`define LINE_ACTIVE_N      1'b0

`endif

// ==== floppy_option_pkg.sv ====
package floppy_option_pkg;

    // cable lines from the host, all low true
    typedef struct packed {
        logic [3:0] drive_sel_n;
        logic       head_load_n;
        logic       side_select_n;
        logic       direction_n;
        logic       write_gate_n;
        logic [3:0] motor_line_n;
    } cable_in_t;

    // mechanism sensors, high true
    typedef struct packed {
        logic two_sided_hole;
        logic write_protect;
        logic index_hole;
    } sensor_t;

    typedef struct packed {
        logic [3:0] drive_address_straps;
        logic [3:0] per_drive_head_select_straps;
        logic [3:0] per_drive_motor_lines;
        logic       stepper_power_from_select_strap;
        logic       stepper_power_from_head_load_strap;
        logic       head_load_output_pad_strap;
        logic       activity_from_head_load_strap;
        logic       allow_write_on_protect_strap;
        logic       head_by_direction_strap;
        logic       head_by_side_input_strap;
        logic       head_by_select_strap;
        logic       motor_off_delay_enable;
        logic       radial_motor_enable;
        logic       motor_from_select;
        logic       motor_from_head_load;
    } straps_t;

    // status lines to the host, low true
    typedef struct packed {
        logic two_sided_media_status_n;
        logic write_protect_n;
        logic index_n;
        logic ready_n;
    } cable_out_t;

    // internal drive controls, high true
    typedef struct packed {
        logic write_gate_int;
        logic stepper_power;
        logic head_select;
        logic head_load_solenoid;
        logic activity_led;
        logic lever_lock_enable;
        logic motor_on;
        logic at_speed;
        logic speed_ok;
    } drive_ctl_t;

    typedef enum logic [1:0] {
        MOTOR_IDLE  = 2'b00,
        MOTOR_RUN   = 2'b01,
        MOTOR_DELAY = 2'b10
    } motor_state_t;

endpackage

// ==== pin_sync.sv ====
`timescale 1ns/1ns
module pin_sync #(
    parameter int unsigned        WIDTH = 1,
    parameter logic [WIDTH-1:0]   INIT  = '0
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             srst,
    // pins in, filtered level out
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] ff1_q;
    logic [WIDTH-1:0] ff2_q;
    logic [WIDTH-1:0] ff3_q;
    logic [WIDTH-1:0] q_q;
    logic [WIDTH-1:0] q_d;

    if (WIDTH == 0) begin : g_chk
        $error("pin_sync needs a nonzero width");
    end

    // ff1 is read only by ff2; a bit moves only once ff2 and ff3 agree
    always_comb begin
        q_d = (ff2_q & ~(ff2_q ^ ff3_q)) | (q_q & (ff2_q ^ ff3_q));
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ff1_q <= INIT;
            ff2_q <= INIT;
            ff3_q <= INIT;
            q_q   <= INIT;
        end else begin
            ff1_q <= d;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
            q_q   <= q_d;
        end
    end

    assign q = q_q;
endmodule // pin_sync

// ==== host_ctrl_model.sv ====
`timescale 1ns/1ns
module host_ctrl_model #(
    parameter int SETTLE = 8
) (
    // clock
    input  wire logic                         clock,
    // requested cable levels from the bench
    input  wire floppy_option_pkg::cable_in_t cmd,
    // cable towards the drive
    output floppy_option_pkg::cable_in_t      cable_in
);
    import floppy_option_pkg::*;

    int        settle_cnt = 0;
    logic      newly_sel;
    cable_in_t next_in;

    // lines move just after the rising edge, never on the sampling edge
    always @(posedge clock) begin
        newly_sel = |(~cmd.drive_sel_n & cable_in.drive_sel_n);
        next_in   = cmd;
        // direction held while the stepper electronics settle after select
        if (newly_sel || settle_cnt != 0) begin
            next_in.direction_n = cable_in.direction_n;
        end
        cable_in <= next_in;
        if (newly_sel) begin
            settle_cnt <= SETTLE;
        end else if (settle_cnt != 0) begin
            settle_cnt <= settle_cnt - 1;
        end
    end
endmodule // host_ctrl_model

// ==== floppy_option_ctrl_test.sv ====
`timescale 1ns/1ns
module floppy_option_ctrl_test;
    import floppy_option_pkg::*;

    logic       clock;
    logic       srst;
    straps_t    straps;
    cable_in_t  cmd;
    cable_in_t  cable_in;
    sensor_t    sensors;
    cable_out_t cout;
    drive_ctl_t drv;
    logic       two_sided;
    logic       wp;
    logic       idx;
    int         idx_period;
    int         idx_cnt;
    int         fails;
    int         n_compared;

    assign sensors = {two_sided, wp, idx};

    host_ctrl_model host (.clock(clock), .cmd(cmd), .cable_in(cable_in));

    // short counts keep the run small; all waits below derive from them
    floppy_option_ctrl #(
        .OFF_DELAY_CYCLES(40), .SPIN_UP_CYCLES(10), .READY_CYCLES(20),
        .INDEX_PERIOD_CYCLES(100), .INDEX_TOL_CYCLES(5)
    ) dut (
        .clock(clock), .srst(srst), .straps(straps), .cable_in(cable_in),
        .sensors(sensors), .cable_out(cout), .drive_ctl(drv)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        idx = 1'b0;
        idx_cnt = 0;
        forever begin
            @(negedge clock);
            if (idx_period == 0) begin
                idx = 1'b0;
                idx_cnt = 0;
            end else begin
                idx_cnt = (idx_cnt + 1) % idx_period;
                idx = (idx_cnt < 4);
            end
        end
    end

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: return drv.motor_on;
            1: return cout.ready_n;
            2: return drv.at_speed;
            3: return drv.speed_ok;
            default: return cout.index_n;
        endcase
    endfunction

    // bounded wait; running out of cycles ends the run as a failure
    task automatic wait_on(input int w, input logic v, input int bound);
        int i;
        i = 0;
        while (pick(w) !== v && i < bound) begin
            cyc(1);
            i++;
        end
        chk(pick(w), v);
        if (pick(w) !== v) begin
            stop_test();
        end
    endtask

    task automatic sel(input logic on);
        cmd.drive_sel_n = on ? 4'he : 4'hf;
    endtask

    task automatic defaults();
        straps = '0;
        straps.drive_address_straps = 4'h1;
        straps.stepper_power_from_head_load_strap = 1'b1;
        straps.head_by_side_input_strap = 1'b1;
        straps.motor_off_delay_enable = 1'b1;
        straps.motor_from_select = 1'b1;
        cmd = 12'hfff;
        two_sided = 1'b0;
        wp = 1'b0;
        idx_period = 0;
    endtask

    task automatic do_reset(input int n);
        srst = 1'b1;
        cyc(n);
        chk(cout, 4'hf);
        chk(drv, 9'h0);
        srst = 1'b0;
    endtask

    task automatic t_status_gating();
        two_sided = 1'b1;
        wp = 1'b1;
        cyc(8);
        chk(cout.two_sided_media_status_n, 1'b1);
        sel(1'b1);
        cyc(8);
        chk(cout.two_sided_media_status_n, 1'b0);
        chk(cout.write_protect_n, 1'b0);
        cmd.write_gate_n = 1'b0;
        cyc(8);
        chk(drv.write_gate_int, 1'b0);
        straps.allow_write_on_protect_strap = 1'b1;
        cyc(3);
        chk(drv.write_gate_int, 1'b1);
        chk(cout.write_protect_n, 1'b0);
        sel(1'b0);
        cyc(8);
        chk(cout, 4'hf);
        defaults();
    endtask

    task automatic t_stepper_led();
        cmd.head_load_n = 1'b0;
        cyc(8);
        chk(drv.stepper_power, 1'b0);
        sel(1'b1);
        cyc(8);
        chk(drv.stepper_power, 1'b1);
        chk(drv.activity_led, 1'b1);
        chk(drv.head_load_solenoid, 1'b0);
        straps.head_load_output_pad_strap = 1'b1;
        cyc(3);
        chk(drv.head_load_solenoid, 1'b1);
        cmd.head_load_n = 1'b1;
        cyc(8);
        chk(drv.stepper_power, 1'b0);
        chk(drv.head_load_solenoid, 1'b0);
        straps.activity_from_head_load_strap = 1'b1;
        cyc(3);
        chk(drv.activity_led, 1'b0);
        chk(drv.lever_lock_enable, 1'b0);
        straps.stepper_power_from_head_load_strap = 1'b0;
        straps.stepper_power_from_select_strap = 1'b1;
        cyc(3);
        chk(drv.stepper_power, 1'b1);
        sel(1'b0);
        cmd.head_load_n = 1'b0;
        cyc(8);
        chk(drv.stepper_power, 1'b0);
        chk(drv.activity_led, 1'b1);
        chk(drv.lever_lock_enable, 1'b1);
        defaults();
    endtask

    task automatic t_head_select();
        sel(1'b1);
        cmd.side_select_n = 1'b0;
        cyc(16);
        chk(drv.head_select, 1'b1);
        cmd.side_select_n = 1'b1;
        cyc(8);
        chk(drv.head_select, 1'b0);
        straps.head_by_side_input_strap = 1'b0;
        straps.head_by_direction_strap = 1'b1;
        cmd.direction_n = 1'b0;
        cyc(8);
        chk(drv.head_select, 1'b1);
        straps.head_by_direction_strap = 1'b0;
        straps.head_by_select_strap = 1'b1;
        straps.per_drive_head_select_straps = 4'h2;
        cyc(3);
        chk(drv.head_select, 1'b0);
        straps.per_drive_head_select_straps = 4'h1;
        cyc(3);
        chk(drv.head_select, 1'b1);
        defaults();
        cyc(8);
    endtask

    task automatic t_motor_select();
        // earlier scenarios selected the drive, so let the off delay run out first
        wait_on(0, 1'b0, 60);
        sel(1'b1);
        wait_on(0, 1'b1, 15);
        chk(drv.at_speed, 1'b0);
        cyc(14);
        chk(cout.ready_n, 1'b1);
        wait_on(2, 1'b1, 5);
        wait_on(1, 1'b0, 20);
        sel(1'b0);
        cyc(30);
        chk(cout.ready_n, 1'b1);
        chk(drv.motor_on, 1'b1);
        wait_on(0, 1'b0, 40);
        straps.motor_off_delay_enable = 1'b0;
        sel(1'b1);
        wait_on(0, 1'b1, 15);
        sel(1'b0);
        wait_on(0, 1'b0, 10);
        defaults();
    endtask

    task automatic t_motor_head_load();
        straps.motor_from_head_load = 1'b1;
        cmd.head_load_n = 1'b0;
        cyc(20);
        chk(drv.motor_on, 1'b0);
        straps.motor_from_select = 1'b0;
        wait_on(0, 1'b1, 15);
        cmd.head_load_n = 1'b1;
        cyc(30);
        chk(drv.motor_on, 1'b1);
        wait_on(0, 1'b0, 40);
        defaults();
    endtask

    task automatic t_radial();
        straps.motor_from_select = 1'b0;
        straps.radial_motor_enable = 1'b1;
        straps.per_drive_motor_lines = 4'h1;
        wait_on(0, 1'b1, 15);
        cmd.motor_line_n = 4'he;
        wait_on(0, 1'b0, 10);
        straps.per_drive_motor_lines = 4'h2;
        wait_on(0, 1'b1, 10);
        straps.per_drive_motor_lines = 4'h0;
        cyc(10);
        chk(drv.motor_on, 1'b1);
        straps.radial_motor_enable = 1'b0;
        wait_on(0, 1'b0, 10);
        defaults();
    endtask

    task automatic t_speed_and_reset();
        sel(1'b1);
        idx_period = 100;
        wait_on(0, 1'b1, 15);
        wait_on(3, 1'b1, 350);
        wait_on(4, 1'b0, 120);
        idx_period = 160;
        wait_on(3, 1'b0, 400);
        do_reset(4);
        cyc(1);
        chk(drv.motor_on, 1'b0);
        defaults();
    endtask

    initial begin
        fails = 0;
        n_compared = 0;
        defaults();
        srst = 1'b1;
        cyc(15);
        do_reset(1);
        t_status_gating();
        t_stepper_led();
        t_head_select();
        t_motor_select();
        t_motor_head_load();
        t_radial();
        t_speed_and_reset();
        stop_test();
    end
endmodule // floppy_option_ctrl_test
